//--- src/ppc_pkg.sv
// Purpose: Shared offsets, field positions and reset values for the
//          per-port PHY control and status register bank.
// Assumes: Byte-wide registers on the switch register access port.
// Notes:   Offsets are byte addresses of the switch register space.
package ppc_pkg;

    // Register offsets
    localparam logic [7:0] P1_AN_CTRL_ADDR = 8'h2C;
    localparam logic [7:0] P1_MISC_CTRL_ADDR = 8'h2D;
    localparam logic [7:0] P1_LINK_STAT_ADDR = 8'h2E;
    localparam logic [7:0] P2_AN_CTRL_ADDR = 8'h3C;
    localparam logic [7:0] P2_MISC_CTRL_ADDR = 8'h3D;
    localparam logic [7:0] P2_LINK_STAT_ADDR = 8'h3E;
    localparam logic [7:0] P3_LOOP_CTRL_ADDR = 8'h4D;
    localparam logic [7:0] P4_LOOP_CTRL_ADDR = 8'h5D;

    // Autoneg control field positions
    localparam int AN_DISABLE_BIT = 7;
    localparam int FORCE_SPEED_BIT = 6;
    localparam int FORCE_DUPLEX_BIT = 5;
    localparam int ADV_HI_BIT = 4;

    // Misc control field positions
    localparam int LED_OFF_BIT = 7;
    localparam int TX_DISABLE_BIT = 6;
    localparam int RESTART_AN_BIT = 5;
    localparam int POWER_DOWN_BIT = 3;
    localparam int MDIX_AUTO_OFF_BIT = 2;
    localparam int FORCE_MDI_BIT = 1;
    localparam int MAC_LOOP_BIT = 0;

    // Writable mask of misc control for PHY ports (bit 5 self clears)
    localparam logic [7:0] MISC_RW_MASK = 8'hCF;
    // Writable mask of misc control for MAC-only ports
    localparam logic [7:0] LOOP_RW_MASK = 8'h01;

    // Reset values
    localparam logic [7:0] AN_CTRL_RESET = 8'h5F;
    localparam logic [7:0] MISC_CTRL_RESET = 8'h00;
    localparam logic [7:0] LINK_STAT_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // Per-port PHY control toward the analog and negotiation engine
    typedef struct packed {
        logic an_enable;
        logic speed_100;
        logic full_duplex;
        logic [4:0] advertise;
        logic restart_an;
        logic tx_disable;
        logic power_down;
        logic auto_mdix;
        logic force_mdi;
        logic led_off;
    } ppc_phy_ctrl_type;

    // Per-port status from the PHY
    typedef struct packed {
        logic mdi_state;
        logic an_done;
        logic link_good;
        logic [4:0] partner_abil;
    } ppc_phy_stat_type;

endpackage : ppc_pkg

//--- src/ppc_port_regs.sv
// Purpose: Control and status registers of one copper PHY port.
// Assumes: Write strobes come from the bank decoder; reads are muxed there.
// Notes:   Status inputs are synchronised here before being read.
module ppc_port_regs (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic an_wr,
    input wire logic misc_wr,
    input wire logic [7:0] wr_data,
    input wire ppc_pkg::ppc_phy_stat_type stat_in,
    input wire logic led_a_in,
    input wire logic led_b_in,
    output logic [7:0] an_ctrl,
    output logic [7:0] misc_ctrl,
    output logic [7:0] link_stat,
    output ppc_pkg::ppc_phy_ctrl_type phy_ctrl,
    output logic port_led_out_a,
    output logic port_led_out_b
);

    logic [7:0] next_an_ctrl;
    logic [7:0] next_misc_ctrl;
    logic [7:0] sync_1;
    logic [7:0] sync_2;
    logic [7:0] sync_3;
    logic [7:0] next_link_stat;
    logic an_fail;

    // Register updates on software writes
    always_comb begin
        next_an_ctrl = an_ctrl;
        next_misc_ctrl = misc_ctrl;
        next_misc_ctrl[ppc_pkg::RESTART_AN_BIT] = 1'b0;
        if (an_wr) begin
            next_an_ctrl = wr_data;
        end
        if (misc_wr) begin
            next_misc_ctrl = wr_data & (ppc_pkg::MISC_RW_MASK |
                (8'h01 << ppc_pkg::RESTART_AN_BIT));
        end
    end

    // Status filter: a change is taken once stages two and three agree
    always_comb begin
        next_link_stat = link_stat;
        if (sync_2 == sync_3) begin
            next_link_stat = sync_3;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            an_ctrl <= ppc_pkg::AN_CTRL_RESET;
            misc_ctrl <= ppc_pkg::MISC_CTRL_RESET;
            sync_1 <= ppc_pkg::LINK_STAT_RESET;
            sync_2 <= ppc_pkg::LINK_STAT_RESET;
            sync_3 <= ppc_pkg::LINK_STAT_RESET;
            link_stat <= ppc_pkg::LINK_STAT_RESET;
        end else begin
            an_ctrl <= next_an_ctrl;
            misc_ctrl <= next_misc_ctrl;
            sync_1 <= stat_in;
            sync_2 <= sync_1;
            sync_3 <= sync_2;
            link_stat <= next_link_stat;
        end
    end

    // Negotiation failed: done without a good link
    assign an_fail = link_stat[6] & ~link_stat[5];

    // PHY control derived from the registers
    always_comb begin
        phy_ctrl.an_enable = ~an_ctrl[ppc_pkg::AN_DISABLE_BIT];
        phy_ctrl.speed_100 = an_ctrl[ppc_pkg::FORCE_SPEED_BIT];
        phy_ctrl.full_duplex = an_ctrl[ppc_pkg::FORCE_DUPLEX_BIT] &
            (an_ctrl[ppc_pkg::AN_DISABLE_BIT] | an_fail);
        phy_ctrl.advertise = an_ctrl[ppc_pkg::ADV_HI_BIT:0];
        phy_ctrl.restart_an = misc_ctrl[ppc_pkg::RESTART_AN_BIT];
        phy_ctrl.tx_disable = misc_ctrl[ppc_pkg::TX_DISABLE_BIT];
        phy_ctrl.power_down = misc_ctrl[ppc_pkg::POWER_DOWN_BIT];
        phy_ctrl.auto_mdix = ~misc_ctrl[ppc_pkg::MDIX_AUTO_OFF_BIT];
        phy_ctrl.force_mdi = misc_ctrl[ppc_pkg::MDIX_AUTO_OFF_BIT] &
            misc_ctrl[ppc_pkg::FORCE_MDI_BIT];
        phy_ctrl.led_off = misc_ctrl[ppc_pkg::LED_OFF_BIT];
    end

    assign port_led_out_a = misc_ctrl[ppc_pkg::LED_OFF_BIT] | led_a_in;
    assign port_led_out_b = misc_ctrl[ppc_pkg::LED_OFF_BIT] | led_b_in;

endmodule : ppc_port_regs

//--- src/ppc_regs.sv
// Purpose: Register bank for the two PHY ports and the MAC loopback
//          bits of the two MII ports.
// Assumes: Byte access port of the switch management interface;
//          status and LED inputs arrive asynchronously from the PHYs.
// Notes:   Reads are registered; unmapped reads return zero.
//
// Operation
// - Autoneg disable bit stops negotiation; speed and duplex come from bits.
// - Forced speed bit: 1 selects 100, 0 selects 10; resets to 1.
// - Forced duplex: 1 full, 0 half, when negotiation off or failed.
// - Bits 4..0 of autoneg control gate each advertised ability.
// - LED off bit forces both port LED outputs high.
// - Power-down bit places the port PHY in power-down.
// - Crossover disable bit turns off automatic MDI/MDI-X selection.
// - With auto crossover off, forced MDI picks MDI, else MDI-X.
// - Port 1 loopback bit loops frames at port 1 MAC.
// - Ports 3 and 4 loopback bit loops that MAC, port 2 monitors.
// - Ports 3 and 4 misc control bits 7..1 are reserved.
// - Status bits 4..0 report link partner abilities, read only.
module ppc_regs (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire ppc_pkg::ppc_phy_stat_type p1_stat,
    input wire ppc_pkg::ppc_phy_stat_type p2_stat,
    input wire logic [1:0] p1_led_in,
    input wire logic [1:0] p2_led_in,
    output ppc_pkg::ppc_phy_ctrl_type p1_ctrl,
    output ppc_pkg::ppc_phy_ctrl_type p2_ctrl,
    output logic p1_port_led_out_a,
    output logic p1_port_led_out_b,
    output logic p2_port_led_out_a,
    output logic p2_port_led_out_b,
    output logic [3:0] mac_loop_en
);

    logic [7:0] p1_an;
    logic [7:0] p1_misc;
    logic [7:0] p1_link;
    logic [7:0] p2_an;
    logic [7:0] p2_misc;
    logic [7:0] p2_link;
    logic [7:0] p3_loop;
    logic [7:0] p4_loop;
    logic [7:0] next_p3_loop;
    logic [7:0] next_p4_loop;
    logic [7:0] next_rdata;
    logic next_rvalid;

    // Per-port buses of the two copper PHY ports
    wire logic [1:0][7:0] port_an;
    wire logic [1:0][7:0] port_misc;
    wire logic [1:0][7:0] port_link;
    wire ppc_pkg::ppc_phy_stat_type [1:0] port_stat;
    wire ppc_pkg::ppc_phy_ctrl_type [1:0] port_ctrl;
    wire logic [1:0][1:0] port_led_in;
    wire logic [1:0][1:0] port_led_out;

    // Named port pins gathered into and out of the per-port buses
    assign port_stat = {p2_stat, p1_stat};
    assign port_led_in = {p2_led_in, p1_led_in};
    assign {p2_ctrl, p1_ctrl} = port_ctrl;
    assign {p1_port_led_out_b, p1_port_led_out_a} = port_led_out[0];
    assign {p2_port_led_out_b, p2_port_led_out_a} = port_led_out[1];
    assign p1_an = port_an[0];
    assign p2_an = port_an[1];
    assign p1_misc = port_misc[0];
    assign p2_misc = port_misc[1];
    assign p1_link = port_link[0];
    assign p2_link = port_link[1];

    // Copper PHY ports 1 and 2, one register set each
    for (genvar i = 0; i < 2; i++) begin : g_phy_port
        localparam logic [7:0] AN_ADDR = (i == 0) ?
            ppc_pkg::P1_AN_CTRL_ADDR : ppc_pkg::P2_AN_CTRL_ADDR;
        localparam logic [7:0] MISC_ADDR = (i == 0) ?
            ppc_pkg::P1_MISC_CTRL_ADDR : ppc_pkg::P2_MISC_CTRL_ADDR;
        logic an_wr;
        logic misc_wr;
        // Write strobes of this port
        assign an_wr = reg_wr && (reg_addr == AN_ADDR);
        assign misc_wr = reg_wr && (reg_addr == MISC_ADDR);
        ppc_port_regs u_port (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .an_wr(an_wr),
            .misc_wr(misc_wr),
            .wr_data(reg_wdata),
            .stat_in(port_stat[i]),
            .led_a_in(port_led_in[i][0]),
            .led_b_in(port_led_in[i][1]),
            .an_ctrl(port_an[i]),
            .misc_ctrl(port_misc[i]),
            .link_stat(port_link[i]),
            .phy_ctrl(port_ctrl[i]),
            .port_led_out_a(port_led_out[i][0]),
            .port_led_out_b(port_led_out[i][1])
        );
    end : g_phy_port

    // MAC-only port loopback registers
    always_comb begin
        next_p3_loop = p3_loop;
        next_p4_loop = p4_loop;
        if (reg_wr && (reg_addr == ppc_pkg::P3_LOOP_CTRL_ADDR)) begin
            next_p3_loop = reg_wdata & ppc_pkg::LOOP_RW_MASK;
        end
        if (reg_wr && (reg_addr == ppc_pkg::P4_LOOP_CTRL_ADDR)) begin
            next_p4_loop = reg_wdata & ppc_pkg::LOOP_RW_MASK;
        end
    end

    // Read mux, registered
    always_comb begin
        next_rvalid = reg_rd;
        next_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ppc_pkg::P1_AN_CTRL_ADDR: next_rdata = p1_an;
                ppc_pkg::P1_MISC_CTRL_ADDR: next_rdata = p1_misc;
                ppc_pkg::P1_LINK_STAT_ADDR: next_rdata = p1_link;
                ppc_pkg::P2_AN_CTRL_ADDR: next_rdata = p2_an;
                ppc_pkg::P2_MISC_CTRL_ADDR: next_rdata = p2_misc;
                ppc_pkg::P2_LINK_STAT_ADDR: next_rdata = p2_link;
                ppc_pkg::P3_LOOP_CTRL_ADDR: next_rdata = p3_loop;
                ppc_pkg::P4_LOOP_CTRL_ADDR: next_rdata = p4_loop;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            p3_loop <= ppc_pkg::MISC_CTRL_RESET;
            p4_loop <= ppc_pkg::MISC_CTRL_RESET;
            reg_rdata <= ppc_pkg::RDATA_RESET;
            reg_rvalid <= 1'b0;
        end else begin
            p3_loop <= next_p3_loop;
            p4_loop <= next_p4_loop;
            reg_rdata <= next_rdata;
            reg_rvalid <= next_rvalid;
        end
    end

    assign mac_loop_en[0] = p1_misc[ppc_pkg::MAC_LOOP_BIT];
    assign mac_loop_en[1] = p2_misc[ppc_pkg::MAC_LOOP_BIT];
    assign mac_loop_en[2] = p3_loop[ppc_pkg::MAC_LOOP_BIT];
    assign mac_loop_en[3] = p4_loop[ppc_pkg::MAC_LOOP_BIT];

endmodule : ppc_regs

//--- dv/ppc_regs_checker.sv
// Purpose: Concurrent checks on the port register bank.
// Assumes: Port 1 stands in for both PHY ports.
// Notes:   Bound to ppc_regs after the module.
module ppc_regs_checker (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rvalid,
    input wire logic [1:0] p1_led_in,
    input wire ppc_pkg::ppc_phy_ctrl_type p1_ctrl,
    input wire logic p1_port_led_out_a,
    input wire logic p1_port_led_out_b,
    input wire logic [3:0] mac_loop_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic an_w;
    logic misc_w;
    // Decoded port 1 writes
    assign an_w = reg_wr && reg_addr == ppc_pkg::P1_AN_CTRL_ADDR;
    assign misc_w = reg_wr && reg_addr == ppc_pkg::P1_MISC_CTRL_ADDR;
    // Restart pulse lasts one cycle
    sequence restart_s;
        p1_ctrl.restart_an ##1 !p1_ctrl.restart_an;
    endsequence
    read_answer_a: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after strobe");
    forced_mode_a: assert property (an_w |=>
        p1_ctrl.an_enable == !$past(reg_wdata[7]) &&
        p1_ctrl.speed_100 == $past(reg_wdata[6]))
        else $error("forced mode bits not applied");
    advert_gate_a: assert property (an_w |=>
        p1_ctrl.advertise == $past(reg_wdata[4:0]))
        else $error("advertised abilities not applied");
    led_force_a: assert property (p1_ctrl.led_off |->
        p1_port_led_out_a && p1_port_led_out_b)
        else $error("led outputs not forced high");
    led_follow_a: assert property (!p1_ctrl.led_off |->
        {p1_port_led_out_b, p1_port_led_out_a} == p1_led_in)
        else $error("led outputs not following input");
    power_down_a: assert property (misc_w |=>
        p1_ctrl.power_down == $past(reg_wdata[3]))
        else $error("power down not applied");
    mdi_force_a: assert property (misc_w |=>
        p1_ctrl.auto_mdix == !$past(reg_wdata[2]) &&
        p1_ctrl.force_mdi == ($past(reg_wdata[2]) && $past(reg_wdata[1])))
        else $error("crossover control wrong");
    restart_once_a: assert property (
        misc_w && reg_wdata[5] |=> restart_s)
        else $error("restart not a single pulse");
    loop_port3_a: assert property (reg_wr &&
        reg_addr == ppc_pkg::P3_LOOP_CTRL_ADDR |=>
        mac_loop_en[2] == $past(reg_wdata[0]))
        else $error("port 3 loopback not applied");
endmodule : ppc_regs_checker

bind ppc_regs ppc_regs_checker u_chk (.*);

//--- dv/ppc_phy_model.sv
// Purpose: Behavioural PHY and link partner feeding port status.
// Assumes: Partner always answers; link needs power.
// Notes:   Partner abilities are a plain parameter.
module ppc_phy_model #(
    parameter logic [4:0] PARTNER_ABIL = 5'h13
) (
    input wire ppc_pkg::ppc_phy_ctrl_type ctrl,
    input wire logic link_drop,
    output ppc_pkg::ppc_phy_stat_type stat
);
    timeunit 1ns;
    timeprecision 1ps;
    // Crossover outcome, negotiation done when enabled and powered, link
    // when powered unless dropped, then the partner abilities
    assign stat = {!ctrl.auto_mdix && ctrl.force_mdi,
        ctrl.an_enable && !ctrl.power_down,
        !ctrl.power_down && !link_drop, PARTNER_ABIL};
endmodule : ppc_phy_model

//--- dv/port_phy_control_status_regs_bench.sv
// Purpose: Directed register tests of the port register bank.
// Assumes: Inputs change on the falling clock edge.
// Notes:   PHY status comes from two behavioural models.
module port_phy_control_status_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] AN1 = ppc_pkg::P1_AN_CTRL_ADDR;
    localparam logic [7:0] MC1 = ppc_pkg::P1_MISC_CTRL_ADDR;
    localparam logic [7:0] ST1 = ppc_pkg::P1_LINK_STAT_ADDR;
    localparam logic [7:0] LP3 = ppc_pkg::P3_LOOP_CTRL_ADDR;
    localparam logic [7:0] LP4 = ppc_pkg::P4_LOOP_CTRL_ADDR;
    localparam logic [7:0] AN2 = ppc_pkg::P2_AN_CTRL_ADDR;
    localparam logic [7:0] MC2 = ppc_pkg::P2_MISC_CTRL_ADDR;
    logic sys_clk, reset_n, reg_wr, reg_rd, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] p1_led_in, p2_led_in;
    logic [3:0] mac_loop_en;
    logic la1, lb1, la2, lb2, drop1;
    ppc_pkg::ppc_phy_stat_type p1_stat, p2_stat;
    ppc_pkg::ppc_phy_ctrl_type p1_ctrl, p2_ctrl;
    int fails, n_checks;
    ppc_regs dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .p1_stat(p1_stat),
        .p2_stat(p2_stat), .p1_led_in(p1_led_in), .p2_led_in(p2_led_in),
        .p1_ctrl(p1_ctrl), .p2_ctrl(p2_ctrl), .p1_port_led_out_a(la1),
        .p1_port_led_out_b(lb1), .p2_port_led_out_a(la2),
        .p2_port_led_out_b(lb2), .mac_loop_en(mac_loop_en));
    ppc_phy_model m1 (.ctrl(p1_ctrl), .link_drop(drop1), .stat(p1_stat));
    ppc_phy_model #(.PARTNER_ABIL(5'h0C)) m2 (.ctrl(p2_ctrl),
        .link_drop(1'b0), .stat(p2_stat));
    // Clock of 4 ns
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
        input string msg);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        chk({7'h00, reg_rvalid}, 8'h01, "read valid");
        chk(reg_rdata, exp, "read data");
    endtask : rd
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    // Main sequence
    initial begin
        {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 19'h00000;
        p1_led_in = 2'h0;
        p2_led_in = 2'h1;
        drop1 = 1'b0;
        fails = 0;
        n_checks = 0;
        repeat (4) @(negedge sys_clk);
        reset_n = 1'b1;
        rd(AN1, 8'h5F);
        rd(MC1, 8'h00);
        rd(LP4, 8'h00);
        repeat (8) @(negedge sys_clk);
        rd(ST1, 8'h73);
        rd(ppc_pkg::P2_LINK_STAT_ADDR, 8'h6C);
        wr(ST1, 8'hFF);
        rd(ST1, 8'h73);
        rd(8'h10, 8'h00);
        // Negotiation on, then done without a good link
        wr(AN1, 8'h3F);
        chk(p1_ctrl[13:6], 8'h9F, "negotiated, no force");
        drop1 = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk(p1_ctrl[13:6], 8'hBF, "failed, forced full");
        rd(ST1, 8'h53);
        drop1 = 1'b0;
        wr(AN1, 8'h80);
        chk(p1_ctrl[13:6], 8'h00, "forced 10 half");
        wr(AN1, 8'hEA);
        chk(p1_ctrl[13:6], 8'h6A, "forced 100 full");
        rd(AN1, 8'hEA);
        wr(MC1, 8'h80);
        chk({6'h00, la1, lb1}, 8'h03, "led forced");
        wr(MC1, 8'h06);
        chk({5'h00, lb1, p1_ctrl[2:1]}, 8'h01, "forced mdi");
        repeat (8) @(negedge sys_clk);
        rd(ST1, 8'hB3);
        wr(MC1, 8'h02);
        chk({6'h00, p1_ctrl[2:1]}, 8'h02, "auto crossover");
        wr(MC1, 8'h40);
        chk({2'h0, p1_ctrl[5:0]}, 8'h14, "transmit off");
        wr(MC1, 8'h20);
        chk({7'h00, p1_ctrl.restart_an}, 8'h01, "restart set");
        @(negedge sys_clk);
        chk({7'h00, p1_ctrl.restart_an}, 8'h00, "restart clear");
        rd(MC1, 8'h00);
        wr(MC1, 8'h09);
        chk({3'h0, p1_ctrl.power_down, mac_loop_en}, 8'h11, "pd");
        repeat (8) @(negedge sys_clk);
        rd(ST1, 8'h13);
        rd(MC1, 8'h09);
        // Port 2 LEDs and forced mode
        chk({6'h00, lb2, la2}, 8'h01, "port 2 led normal");
        wr(MC2, 8'h80);
        chk({6'h00, lb2, la2}, 8'h03, "port 2 led forced");
        wr(AN2, 8'hC0);
        chk(p2_ctrl[13:6], 8'h40, "port 2 forced 100 half");
        wr(LP3, 8'hFF);
        rd(LP3, 8'h01);
        wr(LP4, 8'hFE);
        rd(LP4, 8'h00);
        wr(LP4, 8'h01);
        chk({4'h0, mac_loop_en}, 8'h0D, "loop enables");
        complete_run();
    end
endmodule : port_phy_control_status_regs_bench
